// File: verilog/fcr_pkg.sv
// constants and types for the floppy configuration register bank
package fcr_pkg;
	// configuration port
	localparam logic [15:0] FCR_PORT_BASE0   = 16'h002E;
	localparam logic [15:0] FCR_PORT_BASE1   = 16'h004E;
	localparam logic [7:0]  FCR_IDX_LDN      = 8'h07;
	localparam logic [7:0]  FCR_IDX_BASE_LO  = 8'h26;
	localparam logic [7:0]  FCR_IDX_BASE_HI  = 8'h27;
	localparam logic [7:0]  FCR_LDN_FLOPPY   = 8'h00;
	localparam logic [7:0]  FCR_LDN_RESET    = 8'h00;
	// register indexes
	localparam logic [7:0]  FCR_IDX_MODE     = 8'hF0;
	localparam logic [7:0]  FCR_IDX_OPTION   = 8'hF1;
	localparam logic [7:0]  FCR_IDX_TYPE     = 8'hF2;
	localparam logic [7:0]  FCR_IDX_RSVD     = 8'hF3;
	localparam logic [7:0]  FCR_IDX_DRIVE0   = 8'hF4;
	localparam logic [7:0]  FCR_IDX_DRIVE1   = 8'hF5;
	// reset values
	localparam logic [7:0]  FCR_MODE_RESET   = 8'h0E;
	localparam logic [7:0]  FCR_OPTION_RESET = 8'h00;
	localparam logic [7:0]  FCR_TYPE_RESET   = 8'hFF;
	localparam logic [7:0]  FCR_DRIVE_RESET  = 8'h00;
	localparam logic [7:0]  FCR_ZERO         = 8'h00;
	// writable bits; reserved bits hold zero
	localparam logic [7:0]  FCR_MODE_WMASK   = 8'hDF;
	localparam logic [7:0]  FCR_OPTION_WMASK = 8'h0D;
	localparam logic [7:0]  FCR_TYPE_WMASK   = 8'hFF;
	localparam logic [7:0]  FCR_DRIVE_WMASK  = 8'h5B;
	// option register fields
	localparam int          FCR_OPT_FWP_BIT  = 0;
	localparam int          FCR_OPT_DEN_LSB  = 2;
	localparam logic [1:0]  FCR_DEN_FORCE1   = 2'h2;
	localparam logic [1:0]  FCR_DEN_FORCE0   = 2'h3;
	// drive that the system boots from
	localparam logic        FCR_BOOT_DRIVE   = 1'h0;

	// host interface variant
	typedef enum logic [1:0] {
		FCR_IF_LEGACY  = 2'h0,
		FCR_IF_ALT     = 2'h1,
		FCR_IF_RSVD    = 2'h2,
		FCR_IF_AT      = 2'h3
	} fcr_iface_t;

	// mode register layout
	typedef struct packed {
		logic       outTristate;
		logic       pushPull;
		logic       rsvd5;
		logic       drive_pin_exchange;
		fcr_iface_t iface;
		logic       nonBurstDma;
		logic       enhanced;
	} fcr_mode_t;

	// per-drive option register layout
	typedef struct packed {
		logic       rsvd7;
		logic       precomp_disable;
		logic       rsvd5;
		logic [1:0] rate_table_sel;
		logic       rsvd2;
		logic [1:0] drive_type_sel;
	} fcr_drive_t;
endpackage

// File: verilog/fcr_sync.sv
// two-flop synchroniser for pin inputs
`timescale 1ns/1ps
module fcr_sync import fcr_pkg::*; #(
	parameter int            W     = 1,
	parameter logic [W-1:0]  RESET = '0
) (
	input  wire logic         core_clk, // system clock
	input  wire logic         resetn,   // sync reset, active low
	input  wire logic [W-1:0] d,        // asynchronous input
	output logic      [W-1:0] q         // synchronised output
);
	logic [W-1:0] meta;
	logic [W-1:0] next_meta;
	logic [W-1:0] next_q;

	// first stage feeds only the second
	always_comb begin
		next_meta = d;
		next_q    = meta;
	end

	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			meta <= RESET;
			q    <= RESET;
		end else begin
			meta <= next_meta;
			q    <= next_q;
		end
	end
endmodule

// File: verilog/fcr_pin_drv.sv
// pad control for the dedicated floppy output pins
`timescale 1ns/1ps
module fcr_pin_drv import fcr_pkg::*; #(
	parameter int W = 5
) (
	input  wire logic [W-1:0] level,    // wanted pin level
	input  wire logic         pushPull, // 1 push-pull, 0 open drain
	input  wire logic         tristate, // 1 release every pin
	output logic      [W-1:0] pinOut,   // pad output value
	output logic      [W-1:0] pinOe     // pad output enable
);
	// open drain only pulls low; the pad releases for a high level
	always_comb begin
		for (int i = 0; i < W; i++) begin
			pinOut[i] = pushPull ? level[i] : 1'b0;
			pinOe[i]  = !tristate && (pushPull || !level[i]);
		end
	end
endmodule

// File: verilog/fcr_config_regs.sv
// floppy configuration register bank with its config port and pin control
//
// Notes on behaviour
// - registers reset only on hard or host bus reset, never soft reset
// - mode bit 0 picks normal (0) or enhanced floppy mode (1)
// - mode bit 1 picks burst (0) or non-burst DMA (1, default)
// - mode bits 3:2 pick host interface variant, 11 default
// - mode bit 4 swaps drive 0 and drive 1 select and motor pins
// - mode bit 6 picks open drain (0) or push-pull (1) outputs
// - mode bit 7 releases all floppy outputs to high impedance
// - output type and release affect dedicated pins only, not port pins
// - forced write protect also covers the parallel port floppy path
// - option bits 3:2 force density high (10) or low (11)
// - type register holds drive A and B types, resets to all ones
// - index F3 is read only and always reads zero
// - drive 0 option holds type and rate table, bits 2,5,7 zero
// - option bit 6 disables write precompensation for that drive
// - index F5 mirrors drive 0 option layout for drive 1
// - drive 0 is always the boot drive
// - config port at 2E or 4E by strap, relocatable by globals
`timescale 1ns/1ps
module fcr_config_regs import fcr_pkg::*; (
	input  wire logic        core_clk,            // 10 MHz clock
	input  wire logic        resetn,              // hard reset, low
	input  wire logic        host_bus_reset_n,    // host bus reset pin
	input  wire logic        softReset,           // soft reset pulse
	input  wire logic        config_port_strap,   // port base strap pin
	// host i/o cycles, already on core_clk
	input  wire logic [15:0] ioAddr,              // i/o address
	input  wire logic        ioWr,                // write pulse
	input  wire logic        ioRd,                // read pulse
	input  wire logic [7:0]  ioWData,             // write data
	output logic      [7:0]  ioRData,             // read data
	output logic             ioRdValid,           // read data valid
	// floppy core side
	input  wire logic [1:0]  coreDriveSelN,       // core selects, low
	input  wire logic [1:0]  coreMotorOnN,        // core motors, low
	input  wire logic        coreDensity,         // core density level
	input  wire logic        floppyWriteProtect,  // device disable bit
	output logic             coreWriteProtect,    // protect to core
	output logic             status_reg_a_wp,     // status A bit 1
	output fcr_mode_t        modeCfg,             // mode settings
	output fcr_drive_t       drive0Cfg,           // drive 0 options
	output fcr_drive_t       drive1Cfg,           // drive 1 options
	output logic [7:0]       driveTypeStore,      // type store
	output logic             bootDrive,           // boot drive number
	// parallel port floppy path
	input  wire logic [1:0]  ppDriveSelN,         // pp path selects
	input  wire logic        ppDiskProtectN,      // pp protect pin
	output logic             ppWriteProtect,      // pp path protect
	// dedicated floppy pins
	input  wire logic        disk_protect_input_n, // protect pin
	output logic             drive0_select_n,     // pin out
	output logic             drive0_select_n_oe,  // pin enable
	output logic             drive1_select_n,     // pin out
	output logic             drive1_select_n_oe,  // pin enable
	output logic [1:0]       motor_on_n,          // pin out
	output logic [1:0]       motor_on_n_oe,       // pin enable
	output logic             densityOut,          // pin out
	output logic             densityOut_oe        // pin enable
);
	// synchronised pins
	logic       busResetN;
	logic       strapSync;
	logic       protectSyncN;
	logic       ppProtectSyncN;
	logic       hardResetN;

	// register state
	logic [7:0]  cfgIndex;
	logic [7:0]  ldn;
	logic [15:0] portBase;
	logic        baseLoaded;
	fcr_mode_t   mode;
	logic [7:0]  option;
	logic [7:0]  typeStore;
	fcr_drive_t  drv0;
	fcr_drive_t  drv1;
	logic [7:0]  rdData;
	logic        rdValid;

	logic [7:0]  next_cfgIndex;
	logic [7:0]  next_ldn;
	logic [15:0] next_portBase;
	logic        next_baseLoaded;
	fcr_mode_t   next_mode;
	logic [7:0]  next_option;
	logic [7:0]  next_typeStore;
	fcr_drive_t  next_drv0;
	fcr_drive_t  next_drv1;
	logic [7:0]  next_rdData;
	logic        next_rdValid;

	// pin outputs
	logic [1:0]  selN;
	logic [1:0]  mtrN;
	logic        density;
	logic        wpCore;
	logic        wpPp;
	logic [1:0]  next_selN;
	logic [1:0]  next_mtrN;
	logic        next_density;
	logic        next_wpCore;
	logic        next_wpPp;

	logic        idxHit;
	logic        dataHit;
	logic        floppySel;
	logic [4:0]  padOut;
	logic [4:0]  padOe;

	// merge masked write into a register
	function automatic logic [7:0] merge(input logic [7:0] cur,
		input logic [7:0] wdata, input logic [7:0] wmask);
		merge = (cur & ~wmask) | (wdata & wmask);
	endfunction

	// forced protect applies while either drive is selected
	function automatic logic protect(input logic [1:0] selLowN,
		input logic forced, input logic pinN, input logic wpBit);
		protect = (!selLowN[0] && forced) || (!selLowN[1] && forced)
			|| !pinN || wpBit;
	endfunction

	fcr_sync #(.W(1), .RESET(1'b1)) uBusRst (
		.core_clk (core_clk),
		.resetn   (resetn),
		.d        (host_bus_reset_n),
		.q        (busResetN)
	);

	// pins run free through reset so the strap is settled at release
	fcr_sync #(.W(3), .RESET(3'h6)) uPins (
		.core_clk (core_clk),
		.resetn   (1'b1),
		.d        ({disk_protect_input_n, ppDiskProtectN,
			config_port_strap}),
		.q        ({protectSyncN, ppProtectSyncN, strapSync})
	);

	// soft reset is deliberately not part of this term
	assign hardResetN = resetn && busResetN;

	// config port decode against the relocatable base
	assign idxHit    = (ioAddr == portBase);
	assign dataHit   = (ioAddr == portBase + 16'h0001);
	assign floppySel = (ldn == FCR_LDN_FLOPPY);

	// register writes and read data
	always_comb begin
		next_cfgIndex   = cfgIndex;
		next_ldn        = ldn;
		next_portBase   = portBase;
		next_baseLoaded = 1'b1;
		next_mode       = mode;
		next_option     = option;
		next_typeStore  = typeStore;
		next_drv0       = drv0;
		next_drv1       = drv1;
		next_rdData     = rdData;
		next_rdValid    = 1'b0;
		// strap is caught on the first cycle after release
		if (!baseLoaded) begin
			next_portBase = strapSync ? FCR_PORT_BASE1
				: FCR_PORT_BASE0;
		end else if (ioWr && idxHit) begin
			next_cfgIndex = ioWData;
		end else if (ioWr && dataHit) begin
			case (cfgIndex)
				FCR_IDX_LDN: begin
					next_ldn = ioWData;
				end
				FCR_IDX_BASE_LO: begin
					next_portBase[7:0] = ioWData;
				end
				FCR_IDX_BASE_HI: begin
					next_portBase[15:8] = ioWData;
				end
				default: begin
					if (floppySel) begin
						case (cfgIndex)
							FCR_IDX_MODE: begin
								next_mode = merge(mode, ioWData,
									FCR_MODE_WMASK);
							end
							FCR_IDX_OPTION: begin
								next_option = merge(option, ioWData,
									FCR_OPTION_WMASK);
							end
							FCR_IDX_TYPE: begin
								next_typeStore = merge(typeStore,
									ioWData, FCR_TYPE_WMASK);
							end
							FCR_IDX_DRIVE0: begin
								next_drv0 = merge(drv0, ioWData,
									FCR_DRIVE_WMASK);
							end
							FCR_IDX_DRIVE1: begin
								next_drv1 = merge(drv1, ioWData,
									FCR_DRIVE_WMASK);
							end
							default: begin
								next_mode = mode;
							end
						endcase
					end
				end
			endcase
		end
		// reads answer one cycle later; unmapped reads give zero
		if (ioRd && idxHit) begin
			next_rdData  = cfgIndex;
			next_rdValid = 1'b1;
		end else if (ioRd && dataHit) begin
			next_rdValid = 1'b1;
			case (cfgIndex)
				FCR_IDX_LDN:     next_rdData = ldn;
				FCR_IDX_BASE_LO: next_rdData = portBase[7:0];
				FCR_IDX_BASE_HI: next_rdData = portBase[15:8];
				default: begin
					next_rdData = FCR_ZERO;
					if (floppySel) begin
						case (cfgIndex)
							FCR_IDX_MODE:   next_rdData = mode;
							FCR_IDX_OPTION: next_rdData = option;
							FCR_IDX_TYPE:   next_rdData = typeStore;
							FCR_IDX_RSVD:   next_rdData = FCR_ZERO;
							FCR_IDX_DRIVE0: next_rdData = drv0;
							FCR_IDX_DRIVE1: next_rdData = drv1;
							default:        next_rdData = FCR_ZERO;
						endcase
					end
				end
			endcase
		end
	end

	// only the hard reset term restores defaults
	always_ff @(posedge core_clk) begin
		if (!hardResetN) begin
			cfgIndex   <= FCR_ZERO;
			ldn        <= FCR_LDN_RESET;
			portBase   <= FCR_PORT_BASE0;
			baseLoaded <= 1'b0;
			mode       <= FCR_MODE_RESET;
			option     <= FCR_OPTION_RESET;
			typeStore  <= FCR_TYPE_RESET;
			drv0       <= FCR_DRIVE_RESET;
			drv1       <= FCR_DRIVE_RESET;
			rdData     <= FCR_ZERO;
			rdValid    <= 1'b0;
		end else begin
			cfgIndex   <= next_cfgIndex;
			ldn        <= next_ldn;
			portBase   <= next_portBase;
			baseLoaded <= next_baseLoaded;
			mode       <= next_mode;
			option     <= next_option;
			typeStore  <= next_typeStore;
			drv0       <= next_drv0;
			drv1       <= next_drv1;
			rdData     <= next_rdData;
			rdValid    <= next_rdValid;
		end
	end

	// pin levels, swap, density and write protect
	always_comb begin
		next_selN = coreDriveSelN;
		next_mtrN = coreMotorOnN;
		if (mode.drive_pin_exchange) begin
			next_selN = {coreDriveSelN[0], coreDriveSelN[1]};
			next_mtrN = {coreMotorOnN[0], coreMotorOnN[1]};
		end
		case (option[FCR_OPT_DEN_LSB +: 2])
			FCR_DEN_FORCE1: next_density = 1'b1;
			FCR_DEN_FORCE0: next_density = 1'b0;
			default:        next_density = coreDensity;
		endcase
		// selects are the core's, before any swap onto the pins
		next_wpCore = protect(coreDriveSelN, option[FCR_OPT_FWP_BIT],
			protectSyncN, floppyWriteProtect);
		next_wpPp = protect(ppDriveSelN, option[FCR_OPT_FWP_BIT],
			ppProtectSyncN, floppyWriteProtect);
	end

	// pins idle deselected while in reset
	always_ff @(posedge core_clk) begin
		if (!hardResetN) begin
			selN    <= 2'h3;
			mtrN    <= 2'h3;
			density <= 1'b0;
			wpCore  <= 1'b0;
			wpPp    <= 1'b0;
		end else begin
			selN    <= next_selN;
			mtrN    <= next_mtrN;
			density <= next_density;
			wpCore  <= next_wpCore;
			wpPp    <= next_wpPp;
		end
	end

	// type and release act on dedicated pads only; pp path bypasses
	fcr_pin_drv #(.W(5)) uPads (
		.level    ({density, mtrN, selN}),
		.pushPull (mode.pushPull),
		.tristate (mode.outTristate),
		.pinOut   (padOut),
		.pinOe    (padOe)
	);

	assign drive0_select_n    = padOut[0];
	assign drive1_select_n    = padOut[1];
	assign motor_on_n         = padOut[3:2];
	assign densityOut         = padOut[4];
	assign drive0_select_n_oe = padOe[0];
	assign drive1_select_n_oe = padOe[1];
	assign motor_on_n_oe      = padOe[3:2];
	assign densityOut_oe      = padOe[4];

	// settings exported to the floppy core
	assign modeCfg          = mode;
	assign drive0Cfg        = drv0;
	assign drive1Cfg        = drv1;
	assign driveTypeStore   = typeStore;
	assign bootDrive        = FCR_BOOT_DRIVE;
	assign coreWriteProtect = wpCore;
	assign status_reg_a_wp  = wpCore;
	assign ppWriteProtect   = wpPp;
	assign ioRData          = rdData;
	assign ioRdValid        = rdValid;
endmodule

// File: testbench/fcr_drive_model.sv
// two floppy drives on pulled-up select, motor and density lines
`timescale 1ns/1ps
module fcr_drive_model (
	input  wire logic       sel0,   // select 0 pad value
	input  wire logic       sel0Oe, // select 0 pad enable
	input  wire logic       sel1,   // select 1 pad value
	input  wire logic       sel1Oe, // select 1 pad enable
	input  wire logic [1:0] mtr,    // motor pad values
	input  wire logic [1:0] mtrOe,  // motor pad enables
	input  wire logic       den,    // density pad value
	input  wire logic       denOe,  // density pad enable
	input  wire logic [1:0] wpTab,  // per-drive tab, 1 protected
	output logic      [4:0] busN,   // den, mtr1, mtr0, sel1, sel0
	output logic            protN   // protect line, low protected
);
	// a released line floats up to its pull-up, never keeps a level
	assign busN = {denOe ? den : 1'b1, mtrOe[1] ? mtr[1] : 1'b1,
		mtrOe[0] ? mtr[0] : 1'b1, sel1Oe ? sel1 : 1'b1,
		sel0Oe ? sel0 : 1'b1};
	// only a selected drive pulls the open collector protect line
	assign protN = !((!busN[0] && wpTab[0]) || (!busN[1] && wpTab[1]));
endmodule

// File: testbench/fcr_config_regs_chk.sv
// port assertions for the floppy configuration register bank
`timescale 1ns/1ps
module fcr_config_regs_chk import fcr_pkg::*; (
	input wire logic       core_clk,           // clock
	input wire logic       resetn,             // reset, low
	input wire logic       ioRd,               // read pulse
	input wire logic       ioWr,               // write pulse
	input wire logic       softReset,          // soft reset pulse
	input wire logic [1:0] coreDriveSelN,      // core selects
	input wire logic       ioRdValid,          // read valid
	input wire logic       coreWriteProtect,   // protect to core
	input wire logic       status_reg_a_wp,    // status A bit
	input wire fcr_mode_t  modeCfg,            // mode settings
	input wire fcr_drive_t drive0Cfg,          // drive 0 options
	input wire logic [7:0] driveTypeStore,     // type store
	input wire logic       bootDrive,          // boot drive
	input wire logic       drive0_select_n,    // pad value
	input wire logic       drive0_select_n_oe, // pad enable
	input wire logic       drive1_select_n_oe, // pad enable
	input wire logic [1:0] motor_on_n_oe,      // pad enables
	input wire logic       densityOut_oe       // pad enable
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!resetn);

	rd_valid_a: assert property (ioRdValid |-> $past(ioRd))
		else $error("read valid without a read");
	soft_hold_a: assert property (softReset && !ioWr |=>
		$stable(modeCfg) && $stable(driveTypeStore) && $stable(drive0Cfg))
		else $error("soft reset changed a register");
	wp_status_a: assert property (coreWriteProtect == status_reg_a_wp)
		else $error("status protect differs from core protect");
	boot_zero_a: assert property (bootDrive == FCR_BOOT_DRIVE)
		else $error("boot drive not drive 0");
	tri_release_a: assert property (modeCfg.outTristate |->
		{drive0_select_n_oe, drive1_select_n_oe, motor_on_n_oe,
		densityOut_oe} == 5'h00) else $error("pins driven while released");
	push_drive_a: assert property (modeCfg.pushPull &&
		!modeCfg.outTristate |-> &{drive0_select_n_oe, drive1_select_n_oe,
		motor_on_n_oe, densityOut_oe}) else $error("push-pull pin undriven");
	od_low_a: assert property (!modeCfg.pushPull && drive0_select_n_oe
		|-> !drive0_select_n) else $error("open drain drove high");
	no_swap_a: assert property (modeCfg.pushPull && !modeCfg.outTristate &&
		!$past(modeCfg.drive_pin_exchange) |->
		drive0_select_n == $past(coreDriveSelN[0]))
		else $error("select 0 not from core select 0");
	swap_a: assert property (modeCfg.pushPull && !modeCfg.outTristate &&
		$past(modeCfg.drive_pin_exchange) |->
		drive0_select_n == $past(coreDriveSelN[1]))
		else $error("select 0 not from core select 1");
	rsvd_zero_a: assert property (!modeCfg.rsvd5 && !drive0Cfg.rsvd7 &&
		!drive0Cfg.rsvd5 && !drive0Cfg.rsvd2)
		else $error("reserved bit set");
endmodule

// File: testbench/tb_top.sv
// self-checking bench for the floppy configuration register bank
`timescale 1ns/1ps
module tb_top import fcr_pkg::*; ;
	logic        core_clk, resetn, hostRstN, softReset, strap, ioWr, ioRd;
	logic [15:0] ioAddr, base;
	logic [7:0]  ioWData, ioRData, v, c;
	logic        ioRdValid, coreWp, srWp, ppWp, protN, boot, coreDen, fwpBit;
	logic [1:0]  selN, mtrN, ppSelN, wpTab, mtr, mtrOe;
	logic        ppProtN, s0, s0Oe, s1, s1Oe, den, denOe;
	fcr_mode_t   modeCfg;
	fcr_drive_t  d0Cfg, d1Cfg;
	logic [7:0]  typeStore, wm[7], rv[7], md[4], wc[6];
	logic [4:0]  busN, e;
	logic [7:0]  expQ[$];
	int          failures, samples_checked;

	fcr_config_regs dut (.core_clk(core_clk), .resetn(resetn),
		.host_bus_reset_n(hostRstN), .softReset(softReset),
		.config_port_strap(strap), .ioAddr(ioAddr), .ioWr(ioWr), .ioRd(ioRd),
		.ioWData(ioWData), .ioRData(ioRData), .ioRdValid(ioRdValid),
		.coreDriveSelN(selN), .coreMotorOnN(mtrN), .coreDensity(coreDen),
		.floppyWriteProtect(fwpBit), .coreWriteProtect(coreWp),
		.status_reg_a_wp(srWp), .modeCfg(modeCfg), .drive0Cfg(d0Cfg),
		.drive1Cfg(d1Cfg), .driveTypeStore(typeStore), .bootDrive(boot),
		.ppDriveSelN(ppSelN), .ppDiskProtectN(ppProtN),
		.ppWriteProtect(ppWp), .disk_protect_input_n(protN),
		.drive0_select_n(s0), .drive0_select_n_oe(s0Oe),
		.drive1_select_n(s1), .drive1_select_n_oe(s1Oe), .motor_on_n(mtr),
		.motor_on_n_oe(mtrOe), .densityOut(den), .densityOut_oe(denOe));
	fcr_drive_model drives (.sel0(s0), .sel0Oe(s0Oe), .sel1(s1),
		.sel1Oe(s1Oe), .mtr(mtr), .mtrOe(mtrOe), .den(den), .denOe(denOe),
		.wpTab(wpTab), .busN(busN), .protN(protN));

	initial begin
		core_clk = 0;
		forever #50 core_clk = ~core_clk;
	end

	task automatic chk(input string nm, input logic [7:0] ex, g);
		samples_checked++;
		if (g !== ex) begin
			failures++;
			$display("BAD %s expected %h seen %h", nm, ex, g);
		end
	endtask
	task automatic conclude;
		$display("checked %0d mismatches %0d", samples_checked, failures);
		if (failures == 0 && samples_checked > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	// one port cycle, driven just after the edge that precedes it
	task automatic io(input logic [15:0] a, input logic w, r,
		input logic [7:0] d);
		@(posedge core_clk);
		#10 ioAddr = a;
		ioWr = w;
		ioRd = r;
		ioWData = d;
	endtask
	task automatic wr(input logic [7:0] i, d);
		io(base, 1, 0, i);
		io(base + 16'h0001, 1, 0, d);
		io(base, 0, 0, 8'h00);
	endtask
	task automatic rd(input logic [7:0] i, ex);
		io(base, 1, 0, i);
		expQ.push_back(ex);
		io(base + 16'h0001, 0, 1, 8'h00);
		io(base, 0, 0, 8'h00);
	endtask
	task automatic rst(input logic s);
		strap = s;
		base = s ? FCR_PORT_BASE1 : FCR_PORT_BASE0;
		resetn = 0;
		repeat (20) @(posedge core_clk);
		#10 resetn = 1;
		@(posedge core_clk);
	endtask
	task automatic settle(input int n);
		repeat (n) @(posedge core_clk);
		#10;
	endtask

	// read data comes a cycle after the request; match it to the oldest note
	always @(posedge core_clk) begin
		#1;
		if (ioRdValid === 1'b1) begin
			if (expQ.size() == 0)
				chk("unasked read", 8'h00, 8'hEE);
			else
				chk("read", expQ.pop_front(), ioRData);
		end
	end

	// far longer than the few hundred cycles the tests need
	initial begin
		repeat (20000) @(posedge core_clk);
		failures++;
		conclude();
	end

	initial begin
		{resetn, softReset, strap, ioWr, ioRd, coreDen, fwpBit} = '0;
		{hostRstN, ppProtN} = 2'h3;
		{selN, mtrN, ppSelN} = 6'h3F;
		{ioAddr, ioWData, wpTab} = '0;
		wm = '{FCR_MODE_WMASK, FCR_OPTION_WMASK, FCR_TYPE_WMASK, 8'h00,
			FCR_DRIVE_WMASK, FCR_DRIVE_WMASK, 8'h00};
		rv = '{8'h0E, 8'h00, 8'hFF, 8'h00, 8'h00, 8'h00, 8'h00};
		md = '{8'h4C, 8'h5C, 8'h1C, 8'hCC};
		wc = '{8'h45, 8'h43, 8'h07, 8'h4C, 8'h14, 8'h66};
		void'($urandom(55));
		rst(0);
		for (int i = 0; i < 7; i++)
			rd(8'hF0 + 8'(i), rv[i]);
		$display("reset values done");
		// random data; reserved and read-only bits must stay zero
		repeat (2) for (int i = 0; i < 7; i++) begin
			v = 8'($urandom);
			wr(8'hF0 + 8'(i), v);
			rd(8'hF0 + 8'(i), v & wm[i]);
			// exported copies must match what the port reads back
			case (i)
				0: chk("mode out", v & wm[i], modeCfg);
				2: chk("type out", v & wm[i], typeStore);
				4: chk("drive0 out", v & wm[i], d0Cfg);
				5: chk("drive1 out", v & wm[i], d1Cfg);
				default: ;
			endcase
		end
		$display("masked writes done");
		wr(FCR_IDX_TYPE, 8'h5A);
		@(posedge core_clk);
		#10 softReset = 1;
		@(posedge core_clk);
		#10 softReset = 0;
		rd(FCR_IDX_TYPE, 8'h5A);
		hostRstN = 0;
		settle(4);
		hostRstN = 1;
		settle(4);
		rd(FCR_IDX_TYPE, FCR_TYPE_RESET);
		rd(FCR_IDX_MODE, FCR_MODE_RESET);
		$display("reset kinds done");
		// pushed, swapped and open drain pins against core levels, released pins against the pull-ups
		foreach (md[k]) begin
			wr(FCR_IDX_MODE, md[k]);
			repeat (4) begin
				{selN, mtrN, coreDen} = 5'($urandom);
				settle(2);
				e = md[k][7] ? 5'h1F : {coreDen, md[k][4] ?
					{mtrN[0], mtrN[1], selN[0], selN[1]} : {mtrN, selN}};
				chk("pins", {3'h0, e}, {3'h0, busN});
			end
		end
		$display("pin modes done");
		wr(FCR_IDX_MODE, 8'h4C);
		for (int k = 0; k < 4; k++) begin
			wr(FCR_IDX_OPTION, 8'(k << 2));
			coreDen = 1'($urandom);
			settle(2);
			e[0] = (k == 2) ? 1'b1 : (k == 3) ? 1'b0 : coreDen;
			chk("density", {7'h0, e[0]}, {7'h0, busN[4]});
		end
		$display("density done");
		// table: exp, protect bit, tabs, selects, forced protect
		foreach (wc[k]) begin
			c = wc[k];
			wr(FCR_IDX_OPTION, {7'h0, c[0]});
			{fwpBit, wpTab, selN} = c[5:1];
			ppSelN = c[2:1];
			settle(6);
			chk("core protect", {7'h0, c[6]}, {7'h0, coreWp});
			e[0] = (c[0] && c[2:1] != 2'h3) || c[5];
			chk("pp protect", {7'h0, e[0]}, {7'h0, ppWp});
		end
		wr(FCR_IDX_MODE, 8'hCC);
		wr(FCR_IDX_OPTION, 8'h01);
		{fwpBit, ppSelN} = 3'h2;
		settle(6);
		chk("pp released", 8'h01, {7'h0, ppWp});
		$display("write protect done");
		// move the port, then hide the floppy registers behind another device
		wr(FCR_IDX_BASE_HI, 8'h01);
		base = 16'h012E;
		rd(FCR_IDX_BASE_HI, 8'h01);
		wr(FCR_IDX_LDN, 8'h03);
		wr(FCR_IDX_MODE, 8'h00);
		rd(FCR_IDX_MODE, 8'h00);
		wr(FCR_IDX_LDN, 8'h00);
		rd(FCR_IDX_MODE, 8'hCC);
		$display("relocation done");
		rst(1);
		rd(FCR_IDX_MODE, FCR_MODE_RESET);
		rst(0);
		rd(FCR_IDX_RSVD, 8'h00);
		$display("port strap done");
		settle(3);
		if (expQ.size() != 0)
			chk("reads left", 8'h00, 8'(expQ.size()));
		conclude();
	end
endmodule

bind fcr_config_regs fcr_config_regs_chk chk (.core_clk(core_clk),
	.resetn(resetn), .ioRd(ioRd), .ioWr(ioWr), .softReset(softReset),
	.coreDriveSelN(coreDriveSelN), .ioRdValid(ioRdValid),
	.coreWriteProtect(coreWriteProtect), .status_reg_a_wp(status_reg_a_wp),
	.modeCfg(modeCfg), .drive0Cfg(drive0Cfg),
	.driveTypeStore(driveTypeStore), .bootDrive(bootDrive),
	.drive0_select_n(drive0_select_n),
	.drive0_select_n_oe(drive0_select_n_oe),
	.drive1_select_n_oe(drive1_select_n_oe),
	.motor_on_n_oe(motor_on_n_oe), .densityOut_oe(densityOut_oe));
